// ===== hdl/nbc_host.sv
// Host controller that drives NAND bus cycles from a register port
// Notes on behaviour
// - Command byte latched: CE low, CLE high, ALE low
// - Address byte latched: CE low, ALE high, CLE low
// - Full address sent as five address cycles
// - Program/erase cycles need write protect high
// - Data bytes written serially, write protect high
// - Read bytes by toggling read strobe, latches low
// - Keep read strobe high while device busy
// - Cycles one, two carry column bits
// - Cycles three to five carry page, block bits
// - Column bit 12 low; bit 11 limits range
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
module nbc_host (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic chipEnable_n,
  output logic cmdLatch,
  output logic addrLatch,
  output logic writeStrobe_n,
  output logic read_strobe_n,
  output logic writeProtect_n,
  output logic [7:0] ioOut,
  output logic ioOe_n,
  input wire logic [7:0] ioIn,
  input wire logic readyBusy_n
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} nbc_state_e;

  nbc_state_e state;
  nbc_state_e next_state;
  nbc_pkg::nbc_kind_e kind;
  nbc_pkg::nbc_kind_e next_kind;
  logic [1:0] ctrl;
  logic [nbc_pkg::COL_W-1:0] column_addr;
  logic [nbc_pkg::ROW_W-1:0] rowAddr;
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic [2:0] addrIdx;
  logic [2:0] next_addrIdx;
  logic errWp;
  logic errCol;
  logic errRefused;
  logic modifyArmed;
  logic devReady;
  logic tmrLoad;
  logic [nbc_pkg::TMR_W-1:0] tmrVal;
  logic tmrDone;

  // Register decode
  wire wrCtrl = regWr && regAddr == nbc_pkg::REG_CTRL;
  wire wrCmd = regWr && regAddr == nbc_pkg::REG_CMD;
  wire wrCol = regWr && regAddr == nbc_pkg::REG_COL;
  wire wrRow = regWr && regAddr == nbc_pkg::REG_ROW;
  wire wrGo = regWr && regAddr == nbc_pkg::REG_ADDR_GO;
  wire wrData = regWr && regAddr == nbc_pkg::REG_DATA;
  wire wrRead = regWr && regAddr == nbc_pkg::REG_READ;
  wire wrStatus = regWr && regAddr == nbc_pkg::REG_STATUS;
  wire selOn = ctrl[nbc_pkg::CTRL_SEL];
  wire wpOff = ctrl[nbc_pkg::CTRL_WP_OFF];
  wire idle = state == S_IDLE;
  wire anyIssue = wrCmd || wrGo || wrData || wrRead;

  // Row layout: block above page
  wire [nbc_pkg::PAGE_W-1:0] page_addr = rowAddr[nbc_pkg::PAGE_W-1:0];
  wire [nbc_pkg::BLOCK_W-1:0] blockAddr =
    rowAddr[nbc_pkg::ROW_W-1:nbc_pkg::PAGE_W];
  wire planeSel = blockAddr[0];

  // Address bytes in bus order
  wire [7:0] addrByte0 = column_addr[7:0];
  wire [7:0] addrByte1 = {3'h0, column_addr[12:8]};
  wire [7:0] addrByte2 = {blockAddr[1:0], page_addr};
  wire [7:0] addrByte3 = blockAddr[9:2];
  wire [7:0] addrByte4 = {6'h00, blockAddr[11:10]};
  wire [7:0] addrByteSel =
    addrIdx == 3'h0 ? addrByte0 :
    addrIdx == 3'h1 ? addrByte1 :
    addrIdx == 3'h2 ? addrByte2 :
    addrIdx == 3'h3 ? addrByte3 : addrByte4;

  // Column must fit within page plus spare
  wire colBad = column_addr[12] ||
    (column_addr[11] && column_addr[10:7] != 4'h0);

  // Command bytes that start or confirm a program or erase
  wire [7:0] cmdByte = regWrData[7:0];
  wire cmdStartsModify = cmdByte == 8'h80 || cmdByte == 8'h85 ||
    cmdByte == 8'h8b || cmdByte == 8'h60;
  wire cmdConfirms = cmdByte == 8'h10 || cmdByte == 8'h11 ||
    cmdByte == 8'h81 || cmdByte == 8'hd0 || cmdByte == 8'hd1;
  wire cmdIsModify = cmdStartsModify || cmdConfirms;

  // Acceptance checks for each kind of request
  wire busyRefuse = anyIssue && (!idle || !selOn);
  wire cmdWpBad = wrCmd && cmdIsModify && !wpOff;
  wire goWpBad = wrGo && modifyArmed && !wpOff;
  wire dinWpBad = wrData && !wpOff;
  wire goColBad = wrGo && colBad;
  wire readBusyBad = wrRead && !devReady;
  wire wpBad = cmdWpBad || goWpBad || dinWpBad;
  wire refuse = busyRefuse || readBusyBad;
  wire accept = anyIssue && !refuse && !wpBad && !goColBad;

  nbc_phase_timer #(
    .W(nbc_pkg::TMR_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .load(tmrLoad),
    .loadVal(tmrVal),
    .done(tmrDone)
  );

  // Phase sequencer
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_addrIdx = addrIdx;
    tmrLoad = 1'b0;
    tmrVal = nbc_pkg::SETUP_LOAD;
    case (state)
      S_IDLE: begin
        if (accept) begin
          next_state = S_SETUP;
          tmrLoad = 1'b1;
          next_addrIdx = 3'h0;
          if (wrCmd) begin
            next_kind = nbc_pkg::K_CMD;
          end else if (wrGo) begin
            next_kind = nbc_pkg::K_ADDR;
          end else if (wrData) begin
            next_kind = nbc_pkg::K_DIN;
          end else begin
            next_kind = nbc_pkg::K_DOUT;
          end
        end
      end
      S_SETUP: begin
        if (tmrDone) begin
          next_state = S_STROBE;
          tmrLoad = 1'b1;
          tmrVal = nbc_pkg::LOW_LOAD;
        end
      end
      S_STROBE: begin
        if (tmrDone) begin
          next_state = S_HOLD;
          tmrLoad = 1'b1;
          tmrVal = nbc_pkg::HOLD_LOAD;
        end
      end
      S_HOLD: begin
        if (tmrDone) begin
          if (kind == nbc_pkg::K_ADDR && addrIdx != nbc_pkg::ADDR_LAST) begin
            next_state = S_SETUP;
            next_addrIdx = addrIdx + 3'h1;
            tmrLoad = 1'b1;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Pin levels for the next cycle
  wire nextActive = next_state != S_IDLE;
  wire nextLow = next_state == S_STROBE;
  wire isWriteKind = next_kind != nbc_pkg::K_DOUT;
  wire next_cmdLatch = nextActive && next_kind == nbc_pkg::K_CMD;
  wire next_addrLatch = nextActive && next_kind == nbc_pkg::K_ADDR;
  wire next_writeStrobe_n = !(nextLow && isWriteKind);
  wire next_read_strobe_n = !(nextLow && !isWriteKind);
  wire next_ioOe_n = !(nextActive && isWriteKind);
  wire [7:0] next_ioOut = next_kind == nbc_pkg::K_ADDR ?
    (next_addrIdx == addrIdx && state != S_IDLE ? addrByteSel :
     next_addrIdx == 3'h0 ? addrByte0 :
     next_addrIdx == 3'h1 ? addrByte1 :
     next_addrIdx == 3'h2 ? addrByte2 :
     next_addrIdx == 3'h3 ? addrByte3 : addrByte4) :
    (state == S_IDLE ? cmdByte : txByte);
  wire captureRx = state == S_STROBE && tmrDone && kind == nbc_pkg::K_DOUT;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      kind <= nbc_pkg::K_CMD;
      addrIdx <= 3'h0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      addrIdx <= next_addrIdx;
    end
  end

  // Pins: chip enable follows select, latches never both high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chipEnable_n <= 1'b1;
      cmdLatch <= 1'b0;
      addrLatch <= 1'b0;
      writeStrobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      writeProtect_n <= 1'b0;
      ioOut <= 8'h00;
      ioOe_n <= 1'b1;
    end else begin
      chipEnable_n <= !selOn;
      cmdLatch <= next_cmdLatch;
      addrLatch <= next_addrLatch;
      writeStrobe_n <= next_writeStrobe_n;
      read_strobe_n <= next_read_strobe_n;
      writeProtect_n <= wpOff;
      ioOut <= next_ioOut;
      ioOe_n <= next_ioOe_n;
    end
  end

  // Software registers and device state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= nbc_pkg::CTRL_RESET;
      column_addr <= '0;
      rowAddr <= '0;
      txByte <= 8'h00;
      rxByte <= 8'h00;
      devReady <= 1'b0;
      modifyArmed <= 1'b0;
    end else begin
      devReady <= readyBusy_n;
      if (wrCtrl) begin
        ctrl <= regWrData[1:0];
      end
      if (wrCol && idle) begin
        column_addr <= regWrData[nbc_pkg::COL_W-1:0];
      end
      if (wrRow && idle) begin
        rowAddr <= regWrData[nbc_pkg::ROW_W-1:0];
      end
      // Command and data bytes both stay on the bus for the whole cycle
      if (accept && (wrCmd || wrData)) begin
        txByte <= regWrData[7:0];
      end
      if (accept && wrCmd) begin
        modifyArmed <= cmdStartsModify;
      end
      if (captureRx) begin
        rxByte <= ioIn;
      end
    end
  end

  // Sticky errors: a new error wins over a write-one clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      errWp <= 1'b0;
      errCol <= 1'b0;
      errRefused <= 1'b0;
    end else begin
      errWp <= (wpBad && !refuse) ||
        (errWp && !(wrStatus && regWrData[nbc_pkg::ST_ERR_WP]));
      errCol <= (goColBad && !refuse) ||
        (errCol && !(wrStatus && regWrData[nbc_pkg::ST_ERR_COL]));
      errRefused <= refuse ||
        (errRefused && !(wrStatus && regWrData[nbc_pkg::ST_ERR_REFUSED]));
    end
  end

  // Read data, valid the cycle after the read strobe
  wire [31:0] statusWord = {25'h0, modifyArmed, planeSel, errRefused,
    errCol, errWp, devReady, !idle};
  wire [31:0] rdMux =
    regAddr == nbc_pkg::REG_CTRL ? {30'h0, ctrl} :
    regAddr == nbc_pkg::REG_COL ? {19'h0, column_addr} :
    regAddr == nbc_pkg::REG_ROW ? {14'h0, rowAddr} :
    regAddr == nbc_pkg::REG_DATA ? {24'h0, rxByte} :
    regAddr == nbc_pkg::REG_STATUS ? statusWord : 32'h0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 32'h0;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 32'h0;
    end
  end
endmodule // nbc_host

// ===== hdl/nbc_phase_timer.sv
// Down counter that times one phase of a bus cycle
`timescale 1ns/1ps
module nbc_phase_timer #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic done
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  assign next_count = load ? loadVal :
    (count != '0 ? count - W'(1) : count);
  // Done must not look at load: the sequencer derives load from done
  assign done = count == '0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // nbc_phase_timer

// ===== hdl/nbc_pkg.sv
// Constants and types shared by the NAND bus-cycle host controller
package nbc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // Pin timing, in ns, for each phase of one bus cycle
  localparam int T_SETUP_NS = 20;
  localparam int T_STROBE_LOW_NS = 50;
  localparam int T_HOLD_NS = 20;
  localparam int SETUP_CYC_I = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_CYC_I =
    (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC_I = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 4;
  localparam logic [TMR_W-1:0] SETUP_LOAD =
    TMR_W'((SETUP_CYC_I < 1 ? 1 : SETUP_CYC_I) - 1);
  localparam logic [TMR_W-1:0] LOW_LOAD =
    TMR_W'((LOW_CYC_I < 1 ? 1 : LOW_CYC_I) - 1);
  localparam logic [TMR_W-1:0] HOLD_LOAD =
    TMR_W'((HOLD_CYC_I < 1 ? 1 : HOLD_CYC_I) - 1);
  // Array geometry
  localparam int COL_W = 13;
  localparam int PAGE_W = 6;
  localparam int BLOCK_W = 12;
  localparam int ROW_W = PAGE_W + BLOCK_W;
  localparam int PAGE_BYTES = 2176;
  localparam int PAGES_PER_BLOCK = 64;
  localparam logic [2:0] ADDR_LAST = 3'h4;
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_COL = 8'h08;
  localparam logic [7:0] REG_ROW = 8'h0c;
  localparam logic [7:0] REG_ADDR_GO = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam logic [7:0] REG_READ = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // Control bits
  localparam int CTRL_SEL = 0;
  localparam int CTRL_WP_OFF = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Status bits
  localparam int ST_SEQ_BUSY = 0;
  localparam int ST_DEV_READY = 1;
  localparam int ST_ERR_WP = 2;
  localparam int ST_ERR_COL = 3;
  localparam int ST_ERR_REFUSED = 4;
  localparam int ST_PLANE = 5;
  localparam int ST_MODIFY = 6;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_DIN, K_DOUT} nbc_kind_e;
endpackage

// ===== test/nbc_flash_model.sv
// Behavioural model of the NAND device on the far side of the host
`timescale 1ns/1ps
module nbc_flash_model #(
  parameter logic [7:0] OUT_BASE = 8'h5a
) (
  input wire logic chipEnable_n,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic writeStrobe_n,
  input wire logic read_strobe_n,
  input wire logic writeProtect_n,
  input wire logic ioOe_n,
  input wire logic busy,
  input wire logic [7:0] ioOut,
  output logic [7:0] ioIn,
  output logic readyBusy_n
);
  logic [7:0] lastCmd = 8'h00, lastDin = 8'h00, outCnt = 8'h00, drv = 8'h00;
  logic [39:0] addr = 40'h0;
  logic [3:0] addrCount = 4'h0;
  wire logic sel = !chipEnable_n;
  wire logic [17:0] row = {addr[33:32], addr[31:16]};
  wire logic plane = row[6];
  wire logic modify = ioOut inside {8'h80, 8'h85, 8'h8b, 8'h60, 8'h10,
    8'h11, 8'h81, 8'hd0, 8'hd1};
  always @(posedge writeStrobe_n)
    if (sel && read_strobe_n && !(cmdLatch && addrLatch)) begin
      if (cmdLatch && (writeProtect_n || !modify)) begin
        lastCmd <= ioOut;
        addrCount <= 4'h0;
        outCnt <= 8'h00;
      end else if (addrLatch) begin
        addr <= {ioOut, addr[39:8]};
        addrCount <= addrCount + 4'h1;
      end else if (!cmdLatch && writeProtect_n)
        lastDin <= ioOut;
    end
  always @(negedge read_strobe_n)
    if (sel && writeStrobe_n && !cmdLatch && !addrLatch) begin
      drv <= OUT_BASE ^ outCnt;
      outCnt <= outCnt + 8'h01;
    end
  // Released bus shows the inverse so stale data never matches
  assign ioIn = (sel && !read_strobe_n && ioOe_n) ? drv : ~drv;
  assign readyBusy_n = !busy;
endmodule // nbc_flash_model

// ===== test/nbc_host_sva.sv
// Pin-level assertions for the NAND bus-cycle host controller
`timescale 1ns/1ps
module nbc_host_sva (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic chipEnable_n,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic writeStrobe_n,
  input wire logic read_strobe_n,
  input wire logic writeProtect_n,
  input wire logic ioOe_n,
  input wire logic readyBusy_n,
  input wire logic [7:0] ioOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_latch_excl: assert property (!(cmdLatch && addrLatch))
    else $error("both latches high");
  a_cmd_cycle: assert property ($rose(writeStrobe_n) && cmdLatch |->
    !chipEnable_n && read_strobe_n && !ioOe_n && $stable(ioOut))
    else $error("bad command cycle");
  a_addr_cycle: assert property ($rose(writeStrobe_n) && addrLatch |->
    !chipEnable_n && read_strobe_n && !ioOe_n && $stable(ioOut))
    else $error("bad address cycle");
  a_modify_wp: assert property ($rose(writeStrobe_n) && cmdLatch &&
    ioOut inside {8'h80, 8'h85, 8'h8b, 8'h60} |-> writeProtect_n)
    else $error("modify command while protected");
  a_din_wp: assert property ($rose(writeStrobe_n) && !cmdLatch &&
    !addrLatch |-> writeProtect_n && !chipEnable_n && read_strobe_n)
    else $error("data byte while protected");
  a_wr_shape: assert property ($fell(writeStrobe_n) |-> !$past(ioOe_n)
    ##1 !writeStrobe_n ##1 writeStrobe_n)
    else $error("write strobe shape");
  a_rd_cycle: assert property ($fell(read_strobe_n) |-> !chipEnable_n &&
    writeStrobe_n && !cmdLatch && !addrLatch && ioOe_n
    ##1 !read_strobe_n ##1 read_strobe_n)
    else $error("bad read cycle");
  a_rd_ready: assert property ($fell(read_strobe_n) |->
    $past(readyBusy_n, 3))
    else $error("read strobe while busy");
  a_desel_quiet: assert property (chipEnable_n |->
    writeStrobe_n && read_strobe_n)
    else $error("strobe while deselected");
  c_cmd: cover property ($rose(writeStrobe_n) && cmdLatch);
  c_addr: cover property ($rose(writeStrobe_n) && addrLatch);
  c_read: cover property ($fell(read_strobe_n));
endmodule // nbc_host_sva
bind nbc_host nbc_host_sva i_nbc_host_sva (.sys_clk, .arst_n,
  .chipEnable_n, .cmdLatch, .addrLatch, .writeStrobe_n, .read_strobe_n,
  .writeProtect_n, .ioOe_n, .readyBusy_n, .ioOut);

// ===== test/test_nbc_host.sv
// Self-checking bench for the NAND bus-cycle host controller
`timescale 1ns/1ps
module test_nbc_host;
  localparam logic [31:0] PLN = 32'h1 << nbc_pkg::ST_PLANE;
  localparam logic [31:0] ERW = 32'h1 << nbc_pkg::ST_ERR_WP;
  localparam logic [31:0] ERC = 32'h1 << nbc_pkg::ST_ERR_COL;
  localparam logic [31:0] ERR = 32'h1 << nbc_pkg::ST_ERR_REFUSED;
  localparam logic [31:0] COLS[3] = '{32'h1000, 32'h880, 32'h87f};
  logic sys_clk = 0, arst_n = 0, regWr = 0, regRd = 0, devBusy = 0;
  logic rdPend = 0;
  logic [7:0] regAddr = 0;
  logic [31:0] regWrData = 0, col, row;
  logic [31:0] expQ[$], mskQ[$];
  logic [15:0] seed = 16'h0041;
  int fails = 0, compares = 0, cyc = 0;
  wire logic [31:0] regRdData;
  wire logic chipEnable_n, cmdLatch, addrLatch, writeStrobe_n;
  wire logic read_strobe_n, writeProtect_n, ioOe_n, readyBusy_n;
  wire logic [7:0] ioOut, ioIn;
  always #20 sys_clk = ~sys_clk;
  nbc_host i_nbc_host (.sys_clk, .arst_n, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .chipEnable_n, .cmdLatch, .addrLatch,
    .writeStrobe_n, .read_strobe_n, .writeProtect_n, .ioOut, .ioOe_n,
    .ioIn, .readyBusy_n);
  nbc_flash_model i_nbc_flash_model (.chipEnable_n, .cmdLatch, .addrLatch,
    .writeStrobe_n, .read_strobe_n, .writeProtect_n, .ioOe_n,
    .busy(devBusy), .ioOut, .ioIn, .readyBusy_n);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // A pin sequence lasts at most 20 cycles
  task automatic go(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (24) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    expQ.push_back(e);
    mskQ.push_back(m);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rdPend) check({8'h0, regRdData & mskQ.pop_front()},
      {8'h0, expQ.pop_front()});
    rdPend <= regRd;
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    check({39'h0, chipEnable_n}, 40'h1);
    rd(nbc_pkg::REG_CTRL, 32'h0, 32'hffffffff);
    rd(8'h20, 32'h0, 32'hffffffff);
    wr(nbc_pkg::REG_CTRL, 32'h3);
    go(nbc_pkg::REG_CMD, 32'h80);
    check({32'h0, i_nbc_flash_model.lastCmd}, 40'h80);
    seed = lfsr(seed);
    col = {21'h0, seed[10:0]};
    seed = lfsr(seed);
    row = {14'h0, seed[1:0], seed};
    wr(nbc_pkg::REG_COL, col);
    wr(nbc_pkg::REG_ROW, row);
    go(nbc_pkg::REG_ADDR_GO, 32'h0);
    check(i_nbc_flash_model.addr, {6'h0, row[17:0], 3'h0, col[12:0]});
    check({36'h0, i_nbc_flash_model.addrCount}, 40'h5);
    check({39'h0, i_nbc_flash_model.plane}, {39'h0, row[6]});
    rd(nbc_pkg::REG_STATUS, row[6] ? PLN : 32'h0, PLN);
    seed = lfsr(seed);
    go(nbc_pkg::REG_DATA, {24'h0, seed[7:0]});
    check({32'h0, i_nbc_flash_model.lastDin}, {32'h0, seed[7:0]});
    go(nbc_pkg::REG_CMD, 32'h0);
    devBusy <= 1'b1;
    repeat (3) @(posedge sys_clk);
    go(nbc_pkg::REG_READ, 32'h0);
    rd(nbc_pkg::REG_STATUS, ERR, ERR);
    devBusy <= 1'b0;
    wr(nbc_pkg::REG_STATUS, 32'hff);
    for (int k = 0; k < 2; k++) begin
      go(nbc_pkg::REG_READ, 32'h0);
      rd(nbc_pkg::REG_DATA, {24'h0, 8'h5a ^ 8'(k)}, 32'hff);
    end
    wr(nbc_pkg::REG_CTRL, 32'h1);
    go(nbc_pkg::REG_CMD, 32'h60);
    check({32'h0, i_nbc_flash_model.lastCmd}, 40'h0);
    rd(nbc_pkg::REG_STATUS, ERW, ERW);
    go(nbc_pkg::REG_CMD, 32'h90);
    check({32'h0, i_nbc_flash_model.lastCmd}, 40'h90);
    for (int k = 0; k < 3; k++) begin
      wr(nbc_pkg::REG_STATUS, 32'hff);
      wr(nbc_pkg::REG_COL, COLS[k]);
      go(nbc_pkg::REG_ADDR_GO, 32'h0);
      rd(nbc_pkg::REG_STATUS, k < 2 ? ERC : 32'h0, ERC);
    end
    wr(nbc_pkg::REG_CTRL, 32'h0);
    go(nbc_pkg::REG_CMD, 32'h70);
    check({32'h0, i_nbc_flash_model.lastCmd}, 40'h90);
    rd(nbc_pkg::REG_STATUS, ERR, ERR);
    // Let the checker take the last read before the run ends
    @(posedge sys_clk);
    print_verdict();
  end
endmodule // test_nbc_host
